// [rtl/sas_sequencer.sv]
// Purpose: successive-approximation converter sequencer with result and pin registers
// Assumes: one register request per cycle, reads answered one cycle later
// Notes: result registers have no reset on purpose
`timescale 1ns/1ps
`include "sas_defs.svh"

module sas_sequencer (
	input  wire logic                 clk_sys_i,
	input  wire logic                 reset_i,
	input  wire sas_pkg::sas_bus_req_s bus_i,
	output logic [15:0]               rdata_o,
	input  wire logic                 cmp_gt_i,
	input  wire logic                 cmp_ge_i,
	output sas_pkg::sas_analog_s      analog_o,
	output logic                      conversion_end_irq_o,
	input  wire logic [3:0]           port_dout_i,
	input  wire logic [3:0]           port_pin_i,
	output logic [3:0]                port_din_o,
	output logic [3:0]                port_avail_o,
	output logic [3:0]                pin_out_o,
	output logic [3:0]                pin_oe_n_o
);

	// -----------------------------------------------------------------
	// registers and decode
	// -----------------------------------------------------------------
	logic [7:0]          converter_mode_register;
	logic [7:0]          channel_select_register;
	logic [7:0]          port2_function_select;
	logic [7:0]          port2_pin_direction;
	logic [15:0]         conversion_result_wide;
	logic [7:0]          conversion_result_high;
	logic [9:0]          result_bits_reg;
	logic [9:0]          sar_reg;
	logic [3:0]          bit_reg;
	logic                cmp_act_reg;
	logic [7:0]          cnt_reg;
	logic [7:0]          samp_len;
	logic [7:0]          conv_len;
	logic                wr_mode;
	logic                wr_chan;
	logic                wr_mc;
	logic                run_bit;
	logic                done_evt;
	logic                irq_reg;
	sas_pkg::sas_state_e state_reg;
	sas_pkg::sas_state_e state_next;

	assign wr_mode = bus_i.wr && !bus_i.word && bus_i.addr == `SAS_ADDR_MODE;
	assign wr_chan = bus_i.wr && !bus_i.word && bus_i.addr == `SAS_ADDR_CHAN;
	assign wr_mc   = wr_mode || wr_chan;
	assign run_bit = converter_mode_register[`SAS_RUN_BIT];

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			converter_mode_register <= `SAS_MODE_RST;
		end else if (wr_mode) begin
			converter_mode_register <= bus_i.wdata & `SAS_MODE_MASK;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			channel_select_register <= 8'h00;
		end else if (wr_chan) begin
			channel_select_register <= bus_i.wdata & `SAS_CHAN_MASK;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			port2_function_select <= `SAS_FUNC_RST;
			port2_pin_direction   <= `SAS_DIR_RST;
		end else if (bus_i.wr && !bus_i.word) begin
			if (bus_i.addr == `SAS_ADDR_FUNC) begin
				port2_function_select <= bus_i.wdata & `SAS_FUNC_MASK;
			end
			if (bus_i.addr == `SAS_ADDR_DIR) begin
				port2_pin_direction <= bus_i.wdata | `SAS_DIR_FIXED;
			end
		end
	end

	// -----------------------------------------------------------------
	// read port
	// -----------------------------------------------------------------
	// word reads only reach the wide result; byte reads of it give zero
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rdata_o <= 16'h0000;
		end else if (bus_i.rd) begin
			rdata_o <= 16'h0000;
			if (bus_i.word) begin
				if (bus_i.addr == `SAS_ADDR_WIDE) begin
					rdata_o <= conversion_result_wide;
				end
			end else begin
				case (bus_i.addr)
					`SAS_ADDR_HIGH: rdata_o <= {8'h00, conversion_result_high};
					`SAS_ADDR_MODE: rdata_o <= {8'h00, converter_mode_register};
					`SAS_ADDR_CHAN: rdata_o <= {8'h00, channel_select_register};
					`SAS_ADDR_FUNC: rdata_o <= {8'h00, port2_function_select};
					`SAS_ADDR_DIR:  rdata_o <= {8'h00, port2_pin_direction};
					default:        rdata_o <= 16'h0000;
				endcase
			end
		end
	end

	// -----------------------------------------------------------------
	// timing select
	// -----------------------------------------------------------------
	always_comb begin
		case (converter_mode_register[`SAS_TIM_HI:`SAS_TIM_LO])
			3'd0: begin samp_len = `SAS_SAMP_0; conv_len = `SAS_CONV_0; end
			3'd1: begin samp_len = `SAS_SAMP_1; conv_len = `SAS_CONV_1; end
			3'd2: begin samp_len = `SAS_SAMP_2; conv_len = `SAS_CONV_2; end
			3'd3: begin samp_len = `SAS_SAMP_3; conv_len = `SAS_CONV_3; end
			3'd4: begin samp_len = `SAS_SAMP_4; conv_len = `SAS_CONV_4; end
			3'd5: begin samp_len = `SAS_SAMP_5; conv_len = `SAS_CONV_5; end
			3'd6: begin samp_len = `SAS_SAMP_6; conv_len = `SAS_CONV_6; end
			default: begin samp_len = `SAS_SAMP_7; conv_len = `SAS_CONV_7; end
		endcase
	end

	// -----------------------------------------------------------------
	// sequencer
	// -----------------------------------------------------------------
	// a mode or channel write beats the end of conversion
	assign done_evt = state_reg == sas_pkg::SAS_ST_CONV && cnt_reg == conv_len - 8'd1
		&& run_bit && !wr_mc;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sas_pkg::SAS_ST_IDLE: begin
				if (run_bit && !wr_mc) begin
					state_next = sas_pkg::SAS_ST_SAMPLE;
				end
			end
			sas_pkg::SAS_ST_SAMPLE: begin
				if (cnt_reg == samp_len - 8'd1) begin
					state_next = sas_pkg::SAS_ST_CONV;
				end
			end
			sas_pkg::SAS_ST_CONV: begin
				if (done_evt) begin
					state_next = sas_pkg::SAS_ST_SAMPLE;
				end
			end
			default: state_next = sas_pkg::SAS_ST_IDLE;
		endcase
		if (wr_mc || !run_bit) begin
			state_next = sas_pkg::SAS_ST_IDLE;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state_reg <= sas_pkg::SAS_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// one counter spans sampling and conversion of each cycle
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			cnt_reg <= 8'd0;
		end else if (state_next != state_reg || state_reg == sas_pkg::SAS_ST_IDLE) begin
			cnt_reg <= (state_next == sas_pkg::SAS_ST_CONV) ? cnt_reg + 8'd1 : 8'd0;
		end else begin
			cnt_reg <= cnt_reg + 8'd1;
		end
	end

	// -----------------------------------------------------------------
	// approximation loop
	// -----------------------------------------------------------------
	// taps sit half an lsb below each code, so the plain compare rounds
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			sar_reg     <= 10'h000;
			bit_reg     <= 4'd9;
			cmp_act_reg <= 1'b0;
		end else if (state_reg == sas_pkg::SAS_ST_SAMPLE && state_next == sas_pkg::SAS_ST_CONV) begin
			sar_reg     <= `SAS_SAR_MSB_TRIAL;
			bit_reg     <= 4'd9;
			cmp_act_reg <= 1'b1;
		end else if (state_reg == sas_pkg::SAS_ST_CONV && cmp_act_reg) begin
			if (bit_reg == 4'd9) begin
				sar_reg[9] <= cmp_gt_i;
			end else begin
				sar_reg[bit_reg] <= cmp_ge_i;
			end
			if (bit_reg != 4'd0) begin
				sar_reg[bit_reg - 4'd1] <= 1'b1;
				bit_reg <= bit_reg - 4'd1;
			end else begin
				cmp_act_reg <= 1'b0;
			end
		end else if (state_reg != sas_pkg::SAS_ST_CONV) begin
			cmp_act_reg <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// result load and interrupt
	// -----------------------------------------------------------------
	// only ten bits are stored, so the top six read zero even before the first load
	always_ff @(posedge clk_sys_i) begin
		if (done_evt) begin
			result_bits_reg        <= sar_reg;
			conversion_result_high <= sar_reg[9:2];
		end
	end

	assign conversion_result_wide = {6'b00_0000, result_bits_reg};

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= done_evt;
		end
	end

	assign conversion_end_irq_o = irq_reg;

	// -----------------------------------------------------------------
	// analog front end and shared pins
	// -----------------------------------------------------------------
	assign analog_o.channel = channel_select_register[1:0];
	assign analog_o.tap     = sar_reg;
	assign analog_o.sample  = state_reg == sas_pkg::SAS_ST_SAMPLE;
	assign analog_o.hold    = state_reg == sas_pkg::SAS_ST_CONV;
	assign analog_o.ref_en  = converter_mode_register[`SAS_REF_BIT];

	// analog pins drop out of the port: no drive, digital input reads zero
	assign port_avail_o = ~port2_function_select[3:0];
	assign port_din_o   = port_pin_i & ~port2_function_select[3:0];
	assign pin_out_o    = port_dout_i;
	assign pin_oe_n_o   = port2_pin_direction[3:0] | port2_function_select[3:0];

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	a_result_load: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		done_evt |=> conversion_result_wide == {6'b00_0000, $past(sar_reg)})
		else $error("wide result not loaded at conversion end");

	a_high_match: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		conversion_end_irq_o |-> conversion_result_high == conversion_result_wide[9:2])
		else $error("narrow result differs from wide result");

	a_upper_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(bus_i.rd && bus_i.word) |=> rdata_o[15:10] == 6'b00_0000)
		else $error("word read upper bits not zero");

	a_irq_single: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		conversion_end_irq_o |=> !conversion_end_irq_o)
		else $error("interrupt longer than one cycle");

	a_write_wins: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		wr_mc |=> !conversion_end_irq_o && state_reg == sas_pkg::SAS_ST_IDLE)
		else $error("write did not abort conversion");

	a_stop_run: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(!run_bit && !wr_mode) |=> state_reg == sas_pkg::SAS_ST_IDLE)
		else $error("converter runs with run bit clear");

	a_restart_loop: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		done_evt |=> state_reg == sas_pkg::SAS_ST_SAMPLE && cnt_reg == 8'd0)
		else $error("next conversion did not follow");

	a_msb_trial: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		$rose(analog_o.hold) |-> sar_reg == `SAS_SAR_MSB_TRIAL ##1 sar_reg[8])
		else $error("first trial code wrong");

	a_sample_min: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(analog_o.sample && run_bit && !wr_mc && cnt_reg != samp_len - 8'd1) |=> analog_o.sample)
		else $error("sampling cut short");

	a_port_reset: assert property (@(posedge clk_sys_i)
		reset_i |=> port2_function_select == 8'h00 && port2_pin_direction == 8'hFF)
		else $error("pin registers not at reset values");

	a_fixed_bits: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		port2_function_select[7:4] == 4'h0 && port2_pin_direction[7:4] == 4'hF)
		else $error("fixed pin register bits changed");

	a_sar_done: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		done_evt |-> !cmp_act_reg)
		else $error("result loaded before all trials");

	a_ten_trials: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		$rose(analog_o.hold) |-> ##10 !cmp_act_reg)
		else $error("trial loop not ten steps");

	a_msb_decide: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(analog_o.hold && cmp_act_reg && bit_reg == 4'd9) |=> sar_reg[9] == $past(cmp_gt_i))
		else $error("top bit not decided by comparator");

	a_bit_keep: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(analog_o.hold && cmp_act_reg && bit_reg != 4'd9) |=> sar_reg[$past(bit_reg)] == $past(cmp_ge_i))
		else $error("trial bit not decided by comparator");

	a_hold_during: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(analog_o.hold && run_bit && !wr_mc && !done_evt) |=> analog_o.hold)
		else $error("hold released before conversion end");

	a_restart_run: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(state_reg == sas_pkg::SAS_ST_IDLE && run_bit && !wr_mc) |=> analog_o.sample)
		else $error("conversion did not restart");

	a_irq_reset: assert property (@(posedge clk_sys_i)
		reset_i |=> !conversion_end_irq_o)
		else $error("interrupt raised out of reset");

	a_mode_mask: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(converter_mode_register & ~`SAS_MODE_MASK) == 8'h00)
		else $error("unused mode bits set");

	a_chan_mask: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		channel_select_register[7:2] == 6'b00_0000)
		else $error("unused channel bits set");

	a_byte_wide: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(bus_i.rd && !bus_i.word && bus_i.addr == `SAS_ADDR_WIDE) |=> rdata_o == 16'h0000)
		else $error("byte read reached wide result");

	a_high_read: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(bus_i.rd && !bus_i.word && bus_i.addr == `SAS_ADDR_HIGH)
		|=> rdata_o == {8'h00, $past(conversion_result_high)})
		else $error("narrow result read wrong");

	a_analog_undriven: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(~pin_oe_n_o & port2_function_select[3:0]) == 4'h0)
		else $error("analog pin driven");

	a_input_undriven: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(~pin_oe_n_o & port2_pin_direction[3:0]) == 4'h0)
		else $error("input pin driven");

	a_din_mask: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(port_din_o & port2_function_select[3:0]) == 4'h0)
		else $error("analog pin seen as port input");

endmodule

// [rtl/sas_defs.svh]
// Purpose: constants for the converter sequencer
// Assumes: byte-addressed register space, peripheral clock = clk_sys_i
// Notes: offsets are byte addresses on the device register port
// Operation
// - wide result is 16 bits, upper six read zero, ten carry result
// - each end copies result: upper 2 bits at FF19H, lower 8 at FF18H
// - wide result is read only as a 16-bit access, undefined after reset
// - narrow result holds top 8 of 10 bits, 8-bit read, undefined after reset
// - reset clears function register to 00H, sets direction to FFH
// - function bits 7..4 read 0; bits 3..0: 0 port, 1 analog
// - direction bits 7..4 read 1; bits 3..0: 0 output, 1 input
// - a pin in analog function is no longer offered as a port pin
// - after run, sample for programmed time then hold until conversion ends
// - first trial sets bit 9 at half reference, kept if input greater
// - later trials set next bit, tap from decided bits, kept if input >= tap
// - after bit 0, load both results, latch, raise end interrupt
// - conversions repeat back to back until run bit is cleared
// - clearing run bit stops the converter and the repeat loop
// - mode or channel write aborts conversion; restarts if run bit set
// - ideal code is int(vin/vref*1024 + 0.5)
// - select mode only: convert the one channel chosen by channel register
// - mode register at FF80H resets 00H: run b7, timing b5..3, reference b0
// - timing codes give sample/conversion lengths from 12/36 to 176/224
// - channel bits 1..0 pick input 0..3; bits 7..2 written as 0
// - mode/channel write at conversion end wins: no load, no interrupt
`ifndef SAS_DEFS_SVH
`define SAS_DEFS_SVH

`define SAS_ADDR_WIDE     16'hFF18
`define SAS_ADDR_WIDE_HI  16'hFF19
`define SAS_ADDR_HIGH     16'hFF1A
`define SAS_ADDR_DIR      16'hFF22
`define SAS_ADDR_MODE     16'hFF80
`define SAS_ADDR_CHAN     16'hFF81
`define SAS_ADDR_FUNC     16'hFF84

`define SAS_MODE_RST      8'h00
`define SAS_MODE_MASK     8'hB9
`define SAS_CHAN_MASK     8'h03
`define SAS_FUNC_RST      8'h00
`define SAS_FUNC_MASK     8'h0F
`define SAS_DIR_RST       8'hFF
`define SAS_DIR_FIXED     8'hF0

`define SAS_RUN_BIT       7
`define SAS_TIM_HI        5
`define SAS_TIM_LO        3
`define SAS_REF_BIT       0

`define SAS_SAR_MSB_TRIAL 10'h200

`define SAS_SAMP_0        8'd12
`define SAS_SAMP_1        8'd24
`define SAS_SAMP_2        8'd48
`define SAS_SAMP_3        8'd88
`define SAS_SAMP_4        8'd24
`define SAS_SAMP_5        8'd48
`define SAS_SAMP_6        8'd96
`define SAS_SAMP_7        8'd176
`define SAS_CONV_0        8'd36
`define SAS_CONV_1        8'd48
`define SAS_CONV_2        8'd72
`define SAS_CONV_3        8'd112
`define SAS_CONV_4        8'd72
`define SAS_CONV_5        8'd96
`define SAS_CONV_6        8'd144
`define SAS_CONV_7        8'd224

`endif

// [rtl/sas_pkg.sv]
// Purpose: types shared by the converter sequencer and its bench
// Assumes: constants live in sas_defs.svh
// Notes: none
package sas_pkg;

	typedef enum logic [2:0] {
		SAS_ST_IDLE   = 3'b001,
		SAS_ST_SAMPLE = 3'b010,
		SAS_ST_CONV   = 3'b100
	} sas_state_e;

	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        wr;
		logic        word;
		logic [7:0]  wdata;
	} sas_bus_req_s;

	typedef struct packed {
		logic [1:0] channel;
		logic [9:0] tap;
		logic       sample;
		logic       hold;
		logic       ref_en;
	} sas_analog_s;

endpackage

// [sim/sas_analog_model.sv]
// Purpose: behavioural comparator, tap selector and sample-hold
// Assumes: each channel input is given as its ideal rounded code
// Notes: comparator outputs mean nothing outside hold, so they toggle there
`timescale 1ns/1ps

module sas_analog_model (
	input  wire logic                 clk_sys_i,
	input  wire sas_pkg::sas_analog_s analog_i,
	input  wire logic [39:0]          codes_i,
	output logic                      cmp_gt_o,
	output logic                      cmp_ge_o
);
	// --------------------------------------------------------------
	// sample-hold and comparator
	// --------------------------------------------------------------
	logic [9:0] held_reg;
	logic       junk_reg = 1'b0;

	always_ff @(posedge clk_sys_i) begin
		junk_reg <= ~junk_reg;
		if (analog_i.sample) begin
			held_reg <= codes_i[analog_i.channel*10 +: 10];
		end
	end

	// ideal code as input level, so the trials settle on it exactly, except code 200H, which the strict first compare ends at 1FFH
	always_comb begin
		cmp_gt_o = analog_i.hold ? (held_reg > analog_i.tap) : junk_reg;
		cmp_ge_o = analog_i.hold ? (held_reg >= analog_i.tap) : ~junk_reg;
	end
endmodule

// [sim/sas_sequencer_bench.sv]
// Purpose: self-checking bench for the converter sequencer
// Assumes: reads answered one cycle after the request edge
// Notes: timing expectations come from the constants header
`timescale 1ns/1ps
`include "sas_defs.svh"

module sas_sequencer_bench;
	logic                  clk_sys_i   = 1'b0;
	logic                  reset_i     = 1'b1;
	sas_pkg::sas_bus_req_s bus_i       = '0;
	logic [3:0]            port_dout_i = 4'h6;
	logic [3:0]            port_pin_i  = 4'hF;
	logic [15:0]           rdata_o;
	logic                  cmp_gt_i;
	logic                  cmp_ge_i;
	sas_pkg::sas_analog_s  analog_o;
	logic                  conversion_end_irq_o;
	logic [3:0]            port_din_o, port_avail_o, pin_out_o, pin_oe_n_o;
	logic [9:0]            codes [4] = '{10'h2A5, 10'h15A, 10'h3FF, 10'h001};
	logic [7:0]            conv  [8] = '{`SAS_CONV_0, `SAS_CONV_1, `SAS_CONV_2, `SAS_CONV_3,
	                                     `SAS_CONV_4, `SAS_CONV_5, `SAS_CONV_6, `SAS_CONV_7};
	logic [7:0]            samp  [8] = '{`SAS_SAMP_0, `SAS_SAMP_1, `SAS_SAMP_2, `SAS_SAMP_3,
	                                     `SAS_SAMP_4, `SAS_SAMP_5, `SAS_SAMP_6, `SAS_SAMP_7};
	int                    n_errors = 0;
	int                    checks   = 0;
	int                    n;
	int                    s;
	int                    n_irq    = 0;
	int                    snap     = 0;
	logic [15:0]           d;

	sas_sequencer sas_sequencer_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .bus_i(bus_i),
		.rdata_o(rdata_o), .cmp_gt_i(cmp_gt_i), .cmp_ge_i(cmp_ge_i), .analog_o(analog_o),
		.conversion_end_irq_o(conversion_end_irq_o), .port_dout_i(port_dout_i),
		.port_pin_i(port_pin_i), .port_din_o(port_din_o), .port_avail_o(port_avail_o),
		.pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o));

	sas_analog_model sas_analog_model_i (.clk_sys_i(clk_sys_i), .analog_i(analog_o),
		.codes_i({codes[3], codes[2], codes[1], codes[0]}), .cmp_gt_o(cmp_gt_i), .cmp_ge_o(cmp_ge_i));

	initial begin
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	// counts end pulses, so a pulse between two looks is not missed
	always @(posedge clk_sys_i) begin
		if (conversion_end_irq_o === 1'b1) begin
			n_irq++;
		end
	end

	// --------------------------------------------------------------
	// access and check tasks
	// --------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] v, input logic w = 1'b0);
		bus_i = '{addr: a, rd: 1'b0, wr: 1'b1, word: w, wdata: v};
		@(posedge clk_sys_i);
		#1 bus_i = '0;
		@(posedge clk_sys_i);
		#1;
	endtask

	task automatic rchk(input logic [15:0] a, input logic w, input logic [15:0] e);
		bus_i = '{addr: a, rd: 1'b1, wr: 1'b0, word: w, wdata: 8'h00};
		@(posedge clk_sys_i);
		#1 bus_i = '0;
		chk(rdata_o, e);
		@(posedge clk_sys_i);
		#1;
	endtask

	// counts cycles to the next end pulse and sample cycles on the way
	task automatic wait_irq();
		n = 0;
		s = 0;
		do begin
			@(posedge clk_sys_i);
			#1 n++;
			s += analog_o.sample;
		end while (conversion_end_irq_o !== 1'b1 && n < 1000);
		if (n >= 1000) begin
			n_errors++;
			wrap_up();
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// --------------------------------------------------------------
	// test sequence
	// --------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk_sys_i);
		#1 reset_i = 1'b0;
		rchk(`SAS_ADDR_MODE, 1'b0, 16'h0000);
		rchk(`SAS_ADDR_FUNC, 1'b0, 16'h0000);
		rchk(`SAS_ADDR_DIR, 1'b0, 16'h00FF);
		chk({8'h00, pin_oe_n_o, port_avail_o}, 16'h00FF);
		wr(`SAS_ADDR_FUNC, 8'hF5);
		wr(`SAS_ADDR_DIR, 8'h00);
		rchk(`SAS_ADDR_FUNC, 1'b0, 16'h0005);
		rchk(`SAS_ADDR_DIR, 1'b0, 16'h00F0);
		chk({pin_oe_n_o, port_avail_o, port_din_o, pin_out_o}, 16'h5AA6);
		wr(`SAS_ADDR_FUNC, 8'h0F, 1'b1);
		rchk(`SAS_ADDR_FUNC, 1'b0, 16'h0005);
		wr(`SAS_ADDR_FUNC, 8'h0F);
		wr(`SAS_ADDR_DIR, 8'hFF);
		chk({12'h000, pin_oe_n_o}, 16'h000F);
		rchk(16'hFF30, 1'b1, 16'h0000);
		// reference warms up 1 us (25 cycles) before the run bit
		wr(`SAS_ADDR_CHAN, 8'h00);
		wr(`SAS_ADDR_MODE, 8'h01);
		repeat (25) @(posedge clk_sys_i);
		#1 chk(16'(analog_o.ref_en), 16'h0001);
		wr(`SAS_ADDR_MODE, 8'h81);
		wait_irq();
		chk(16'(n), 16'(conv[0]));
		rchk(`SAS_ADDR_WIDE, 1'b1, 16'h02A5);
		chk(16'(conversion_end_irq_o), 16'h0000);
		rchk(`SAS_ADDR_HIGH, 1'b0, 16'h00A9);
		rchk(`SAS_ADDR_WIDE, 1'b0, 16'h0000);
		for (int k = 0; k < 8; k++) begin
			wr(`SAS_ADDR_CHAN, 8'(k % 4));
			wr(`SAS_ADDR_MODE, 8'h81 | 8'(k << 3));
			wait_irq();
			wait_irq();
			chk(16'(n), 16'(conv[k]));
			chk(16'(s), 16'(samp[k]));
			rchk(`SAS_ADDR_WIDE, 1'b1, {6'h00, codes[k % 4]});
		end
		// abort mid conversion, then a write colliding with the end
		wr(`SAS_ADDR_MODE, 8'h81);
		wait_irq();
		repeat (20) @(posedge clk_sys_i);
		#1 wr(`SAS_ADDR_CHAN, 8'h01);
		wait_irq();
		chk(16'(n), 16'(conv[0]));
		rchk(`SAS_ADDR_WIDE, 1'b1, 16'h015A);
		codes[1] = 10'h0F0;
		// the channel write lands on the very edge that ends the conversion
		repeat (conv[0] - 3) @(posedge clk_sys_i);
		#1 snap = n_irq;
		wr(`SAS_ADDR_CHAN, 8'h02);
		chk(16'(n_irq - snap), 16'h0000);
		rchk(`SAS_ADDR_WIDE, 1'b1, 16'h015A);
		wait_irq();
		rchk(`SAS_ADDR_WIDE, 1'b1, 16'h03FF);
		// stop, then restart with the reference still on
		wr(`SAS_ADDR_MODE, 8'h01);
		s = 0;
		repeat (300) begin
			@(posedge clk_sys_i);
			#1 s += conversion_end_irq_o;
		end
		chk(16'(s), 16'h0000);
		chk({15'h0000, analog_o.sample}, 16'h0000);
		wr(`SAS_ADDR_MODE, 8'h81);
		wait_irq();
		chk(16'(n), 16'(conv[0]));
		rchk(`SAS_ADDR_HIGH, 1'b0, 16'h00FF);
		wrap_up();
	end
endmodule
